// File: core/tsa_pkg.sv
/*
 * tsa_pkg: constants shared by the temperature alarm sensor core and its
 * self-checking test bench.
 * assumes: temperatures are 9-bit two's complement codes, 0.5 degree per step.
 */
package tsa_pkg;
    localparam int TEMP_W = 9;
    localparam int CFG_W = 5;
    // slave address upper bits, lower three come from the select pins
    localparam logic [3:0] ADDR_FIXED = 4'h9;
    // pointer values
    localparam logic [1:0] PTR_TEMP = 2'h0;
    localparam logic [1:0] PTR_CFG = 2'h1;
    localparam logic [1:0] PTR_RELEASE = 2'h2;
    localparam logic [1:0] PTR_ALARM = 2'h3;
    localparam logic [1:0] PTR_RST = PTR_TEMP;
    // configuration field positions
    localparam int CFG_SHDN = 0;
    localparam int CFG_INT = 1;
    localparam int CFG_POL = 2;
    localparam int CFG_FQ_LO = 3;
    localparam int CFG_FQ_HI = 4;
    // reset values: comparator, active low, one fault, 80 and 75 degrees
    localparam logic [CFG_W-1:0] CFG_RST = 5'h00;
    localparam logic [TEMP_W-1:0] ALARM_RST = 9'h0A0;
    localparam logic [TEMP_W-1:0] RELEASE_RST = 9'h096;
    localparam logic [TEMP_W-1:0] TEMP_RST = 9'h000;
    // fault queue depths selected by the two-bit field
    localparam logic [2:0] FQ_DEPTH_0 = 3'h1;
    localparam logic [2:0] FQ_DEPTH_1 = 3'h2;
    localparam logic [2:0] FQ_DEPTH_2 = 3'h4;
    localparam logic [2:0] FQ_DEPTH_3 = 3'h6;
    localparam logic [3:0] BIT_LAST = 4'h8;
    // width of the settings word sent to the system side
    localparam int SET_W = CFG_W + 2 * TEMP_W;

    typedef enum logic [3:0] {
        LS_IDLE, LS_ADDR, LS_ADDR_ACK, LS_PTR, LS_PTR_ACK,
        LS_WDATA, LS_WDATA_ACK, LS_RDATA, LS_RDATA_ACK
    } tsa_link_st_t;
endpackage

// File: core/tsa_xfer.sv
/*
 * tsa_xfer: carries one word from a source clock to a destination clock
 * by a toggle request and acknowledge handshake, resending continuously.
 * assumes: both clocks run; the word may change at any time at the source.
 */
`timescale 1ns/1ps
module tsa_xfer #(
    parameter int W = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic i_src_clk,
    input wire logic i_dst_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_src_data,
    output logic [W-1:0] o_dst_data
);
    logic req_r, req_nxt;
    logic [W-1:0] hold_r, hold_nxt;
    logic ack_m_r, ack_s_r;
    logic req_m_r, req_s_r;
    logic ack_r, ack_nxt;
    logic [W-1:0] out_nxt;

    // source: capture a new word once the previous one is acknowledged
    always_comb begin
        req_nxt = req_r;
        hold_nxt = hold_r;
        if (ack_s_r == req_r) begin
            hold_nxt = i_src_data;
            req_nxt = ~req_r;
        end
    end

    always_ff @(posedge i_src_clk or posedge i_rst) begin
        if (i_rst) begin
            req_r <= 1'b0;
            hold_r <= RST_VAL;
            ack_m_r <= 1'b0;
            ack_s_r <= 1'b0;
        end else begin
            req_r <= req_nxt;
            hold_r <= hold_nxt;
            ack_m_r <= ack_r;
            ack_s_r <= ack_m_r;
        end
    end

    // destination: hold word is stable while request differs from acknowledge
    always_comb begin
        ack_nxt = ack_r;
        out_nxt = o_dst_data;
        if (req_s_r != ack_r) begin
            out_nxt = hold_r;
            ack_nxt = req_s_r;
        end
    end

    always_ff @(posedge i_dst_clk or posedge i_rst) begin
        if (i_rst) begin
            req_m_r <= 1'b0;
            req_s_r <= 1'b0;
            ack_r <= 1'b0;
            o_dst_data <= RST_VAL;
        end else begin
            req_m_r <= req_r;
            req_s_r <= req_m_r;
            ack_r <= ack_nxt;
            o_dst_data <= out_nxt;
        end
    end
endmodule

// File: core/tsa_core.sv
/*
 * tsa_core: digital side of a temperature sensor with a two-wire slave port,
 * pointer-selected registers and an over-temperature alarm output.
 * assumes: i_clk_link runs free and oversamples the bus pins; conversion
 * results arrive on i_clk_sys with a one-cycle done pulse; open-drain pins
 * are resolved outside from the enables and pulled up externally.
 */
// Summary of operation
// - reset loads every register with its default
// - defaults comparator, 80/75 degrees, active low, pointer 0
// - slave only, clock input, data both ways
// - address 1001 plus three select pins
// - temperatures are 9-bit two's complement half degrees
// - shutdown bit stops conversions
// - shutdown in interrupt mode clears alert
// - port and settings stay usable in shutdown
// - alert after consecutive faults, in-limit result restarts
// - queue codes select 1, 2, 4, 6 faults
// - comparator alert sets above alarm, clears below release
// - same events both modes, interrupt alert latches
// - any register read clears latched interrupt alert
// - interrupt alerts alternate alarm and release direction
// - alert pin only pulls low or releases
// - polarity bit selects alert active level
// - pointer picks one of four, resets to zero
// - pointer holds until a new pointer byte
// - temperature read only, others read and write
// - config write one byte, limits two bytes
// - read without pointer returns current register
// - upper byte first, most significant bit first
// - last read byte may be acked or not
// - short read may hold data low for clocks
`timescale 1ns/1ps
module tsa_core
    import tsa_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_clk_link,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic [2:0] i_address_select_pins,
    input wire logic [TEMP_W-1:0] i_temp_code,
    input wire logic i_conv_done,
    output logic o_sda_o,
    output logic o_sda_oe,
    output logic o_alert_o,
    output logic o_alert_oe,
    output logic o_conv_run
);
    // link domain state
    logic scl_m_r, scl_s_r, scl_q_r, sda_m_r, sda_s_r, sda_q_r;
    logic [2:0] asel_m_r, asel_s_r;
    tsa_link_st_t st_r, st_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [7:0] hi_r, hi_nxt;
    logic [1:0] ptr_r, ptr_nxt;
    logic [CFG_W-1:0] cfg_r, cfg_nxt;
    logic [TEMP_W-1:0] alarm_r, alarm_nxt, release_r, release_nxt;
    logic idx_r, idx_nxt, rw_r, rw_nxt, nack_r, nack_nxt;
    logic rdtog_r, rdtog_nxt, sda_oe_nxt;
    logic [TEMP_W-1:0] l_temp;
    logic [7:0] rd_first, rd_next;
    logic scl_rise, scl_fall, bus_start, bus_stop;

    // system domain state
    logic rd_m_r, rd_s_r, rd_q_r;
    logic [SET_W-1:0] s_set;
    logic [TEMP_W-1:0] temp_r, temp_nxt;
    logic [2:0] fcnt_r, fcnt_nxt, need;
    logic dir_r, dir_nxt, alert_r, alert_nxt, shdn_q_r;
    logic alert_oe_nxt, conv_run_nxt;
    logic s_shdn, s_int, s_pol, s_conv, s_fault, s_trip, s_read, s_shdn_rise;
    logic [1:0] s_fq;
    logic [TEMP_W-1:0] s_alarm, s_release;

    // read byte for a pointer and byte position, upper byte first
    function automatic logic [7:0] rd_byte(input logic [1:0] p, input logic second,
                                           input logic [TEMP_W-1:0] t, input logic [CFG_W-1:0] c,
                                           input logic [TEMP_W-1:0] rl, input logic [TEMP_W-1:0] al);
        logic [TEMP_W-1:0] v;
        v = t;
        case (p)
            PTR_CFG: v = {1'b0, 3'h0, c};
            PTR_RELEASE: v = rl;
            PTR_ALARM: v = al;
            default: v = t;
        endcase
        if (p == PTR_CFG) begin
            rd_byte = v[7:0];
        end else if (second) begin
            rd_byte = {v[0], 7'h00};
        end else begin
            rd_byte = v[8:1];
        end
    endfunction

    // bus conditions from the synchronised pins
    assign scl_rise = scl_s_r & ~scl_q_r;
    assign scl_fall = ~scl_s_r & scl_q_r;
    assign bus_start = scl_s_r & scl_q_r & sda_q_r & ~sda_s_r;
    assign bus_stop = scl_s_r & scl_q_r & ~sda_q_r & sda_s_r;
    assign rd_first = rd_byte(ptr_r, 1'b0, l_temp, cfg_r, release_r, alarm_r);
    assign rd_next = rd_byte(ptr_r, ~idx_r, l_temp, cfg_r, release_r, alarm_r);

    // two-wire slave engine: sample on clock rise, drive on clock fall
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        hi_nxt = hi_r;
        ptr_nxt = ptr_r;
        cfg_nxt = cfg_r;
        alarm_nxt = alarm_r;
        release_nxt = release_r;
        idx_nxt = idx_r;
        rw_nxt = rw_r;
        nack_nxt = nack_r;
        rdtog_nxt = rdtog_r;
        sda_oe_nxt = o_sda_oe;
        if (bus_start) begin
            st_nxt = LS_ADDR; // repeated start too
            cnt_nxt = 4'h0;
            sda_oe_nxt = 1'b0;
        end else if (bus_stop) begin
            st_nxt = LS_IDLE;
            sda_oe_nxt = 1'b0;
        end else if (scl_rise) begin
            if ((st_r == LS_ADDR || st_r == LS_PTR || st_r == LS_WDATA) && cnt_r != BIT_LAST) begin
                sh_nxt = {sh_r[6:0], sda_s_r};
                cnt_nxt = cnt_r + 4'h1;
            end else if (st_r == LS_RDATA) begin
                cnt_nxt = cnt_r + 4'h1;
            end else if (st_r == LS_RDATA_ACK) begin
                nack_nxt = sda_s_r; // either answer accepted
            end
        end else if (scl_fall) begin
            case (st_r)
                LS_ADDR: begin
                    if (cnt_r == BIT_LAST) begin
                        if (sh_r[7:1] == {ADDR_FIXED, asel_s_r}) begin
                            st_nxt = LS_ADDR_ACK;
                            sda_oe_nxt = 1'b1;
                            rw_nxt = sh_r[0];
                            if (sh_r[0]) begin
                                rdtog_nxt = ~rdtog_r; // any read clears alert
                            end
                        end else begin
                            st_nxt = LS_IDLE;
                        end
                    end
                end
                LS_ADDR_ACK: begin
                    cnt_nxt = 4'h0;
                    idx_nxt = 1'b0;
                    if (rw_r) begin
                        st_nxt = LS_RDATA; // read from latched pointer
                        sh_nxt = rd_first;
                        sda_oe_nxt = ~rd_first[7];
                    end else begin
                        st_nxt = LS_PTR; // pointer byte follows address
                        sda_oe_nxt = 1'b0;
                    end
                end
                LS_PTR: begin
                    if (cnt_r == BIT_LAST) begin
                        ptr_nxt = sh_r[1:0]; // held until next pointer byte
                        st_nxt = LS_PTR_ACK;
                        sda_oe_nxt = 1'b1;
                    end
                end
                LS_PTR_ACK, LS_WDATA_ACK: begin
                    st_nxt = LS_WDATA;
                    sda_oe_nxt = 1'b0;
                    cnt_nxt = 4'h0;
                    idx_nxt = (st_r == LS_PTR_ACK) ? 1'b0 : ~idx_r;
                end
                LS_WDATA: begin
                    if (cnt_r == BIT_LAST) begin
                        st_nxt = LS_WDATA_ACK;
                        sda_oe_nxt = 1'b1;
                        // temperature ignores writes
                        if (ptr_r == PTR_CFG && !idx_r) begin
                            cfg_nxt = sh_r[CFG_W-1:0]; // one byte
                        end else if (ptr_r == PTR_RELEASE || ptr_r == PTR_ALARM) begin
                            if (!idx_r) begin
                                hi_nxt = sh_r;
                            end else if (ptr_r == PTR_RELEASE) begin
                                release_nxt = {hi_r, sh_r[7]}; // two bytes
                            end else begin
                                alarm_nxt = {hi_r, sh_r[7]};
                            end
                        end
                    end
                end
                LS_RDATA: begin
                    if (cnt_r == BIT_LAST) begin
                        st_nxt = LS_RDATA_ACK;
                        sda_oe_nxt = 1'b0;
                    end else begin
                        sh_nxt = {sh_r[6:0], 1'b0};
                        sda_oe_nxt = ~sh_r[6]; // most significant bit first
                    end
                end
                LS_RDATA_ACK: begin
                    if (nack_r) begin
                        st_nxt = LS_IDLE;
                    end else begin
                        st_nxt = LS_RDATA; // next byte, data held low if zero
                        idx_nxt = ~idx_r;
                        sh_nxt = rd_next;
                        sda_oe_nxt = ~rd_next[7];
                        cnt_nxt = 4'h0;
                    end
                end
                default: st_nxt = st_r;
            endcase
        end
    end

    // link registers; pins pass two flops first; reset loads defaults
    always_ff @(posedge i_clk_link or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_q_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_q_r <= 1'b1;
            asel_m_r <= 3'h0;
            asel_s_r <= 3'h0;
            st_r <= LS_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            hi_r <= 8'h00;
            ptr_r <= PTR_RST;
            cfg_r <= CFG_RST;
            alarm_r <= ALARM_RST;
            release_r <= RELEASE_RST;
            idx_r <= 1'b0;
            rw_r <= 1'b0;
            nack_r <= 1'b0;
            rdtog_r <= 1'b0;
            o_sda_oe <= 1'b0;
            o_sda_o <= 1'b0;
        end else begin
            scl_m_r <= i_scl; // clock is input only
            scl_s_r <= scl_m_r;
            scl_q_r <= scl_s_r;
            sda_m_r <= i_sda;
            sda_s_r <= sda_m_r;
            sda_q_r <= sda_s_r;
            asel_m_r <= i_address_select_pins; // strap pins pass two flops too
            asel_s_r <= asel_m_r;
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            hi_r <= hi_nxt;
            ptr_r <= ptr_nxt;
            cfg_r <= cfg_nxt;
            alarm_r <= alarm_nxt;
            release_r <= release_nxt;
            idx_r <= idx_nxt;
            rw_r <= rw_nxt;
            nack_r <= nack_nxt;
            rdtog_r <= rdtog_nxt;
            o_sda_oe <= sda_oe_nxt;
            o_sda_o <= 1'b0;
        end
    end

    // settings to system side, temperature to link side
    tsa_xfer #(.W(SET_W), .RST_VAL({CFG_RST, ALARM_RST, RELEASE_RST})) u_set_xfer (
        .i_src_clk(i_clk_link),
        .i_dst_clk(i_clk_sys),
        .i_rst(i_sys_rst),
        .i_src_data({cfg_r, alarm_r, release_r}),
        .o_dst_data(s_set)
    );
    tsa_xfer #(.W(TEMP_W), .RST_VAL(TEMP_RST)) u_temp_xfer (
        .i_src_clk(i_clk_sys),
        .i_dst_clk(i_clk_link),
        .i_rst(i_sys_rst),
        .i_src_data(temp_r),
        .o_dst_data(l_temp)
    );

    // settings fields and events on the system side
    assign s_shdn = s_set[SET_W-CFG_W+CFG_SHDN];
    assign s_int = s_set[SET_W-CFG_W+CFG_INT];
    assign s_pol = s_set[SET_W-CFG_W+CFG_POL];
    assign s_fq = s_set[SET_W-CFG_W+CFG_FQ_HI:SET_W-CFG_W+CFG_FQ_LO];
    assign s_alarm = s_set[2*TEMP_W-1:TEMP_W];
    assign s_release = s_set[TEMP_W-1:0];
    assign s_read = rd_s_r ^ rd_q_r;
    assign s_shdn_rise = s_shdn & ~shdn_q_r;
    assign s_conv = i_conv_done & ~s_shdn;
    assign s_fault = dir_r ? ($signed(i_temp_code) < $signed(s_release))
                           : ($signed(i_temp_code) > $signed(s_alarm));

    // fault queue depth
    always_comb begin
        case (s_fq)
            2'h0: need = FQ_DEPTH_0;
            2'h1: need = FQ_DEPTH_1;
            2'h2: need = FQ_DEPTH_2;
            2'h3: need = FQ_DEPTH_3;
            default: need = FQ_DEPTH_0;
        endcase
    end
    assign s_trip = s_conv & s_fault & ((fcnt_r + 3'h1) >= need);

    // alarm tracking: count faults, flip direction, drive alert
    always_comb begin
        temp_nxt = s_conv ? i_temp_code : temp_r;
        fcnt_nxt = fcnt_r;
        dir_nxt = dir_r;
        alert_nxt = alert_r;
        if (s_conv) begin
            fcnt_nxt = s_fault ? fcnt_r + 3'h1 : 3'h0;
        end
        if (s_trip) begin
            fcnt_nxt = 3'h0;
            dir_nxt = ~dir_r; // alarm and release alternate
        end
        if (!s_int) begin
            alert_nxt = dir_nxt; // thermostat behaviour
        end else if (s_trip) begin
            alert_nxt = 1'b1; // set beats a clear in the same cycle
        end else if (s_read || s_shdn_rise) begin
            alert_nxt = 1'b0;
        end
        alert_oe_nxt = alert_nxt ^ s_pol; // pull low only
        conv_run_nxt = ~s_shdn;
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rd_m_r <= 1'b0;
            rd_s_r <= 1'b0;
            rd_q_r <= 1'b0;
            temp_r <= TEMP_RST;
            fcnt_r <= 3'h0;
            dir_r <= 1'b0;
            alert_r <= 1'b0;
            shdn_q_r <= 1'b0;
            o_alert_oe <= 1'b0;
            o_alert_o <= 1'b0;
            o_conv_run <= 1'b1;
        end else begin
            rd_m_r <= rdtog_r;
            rd_s_r <= rd_m_r;
            rd_q_r <= rd_s_r;
            temp_r <= temp_nxt;
            fcnt_r <= fcnt_nxt;
            dir_r <= dir_nxt;
            alert_r <= alert_nxt;
            shdn_q_r <= s_shdn;
            o_alert_oe <= alert_oe_nxt;
            o_alert_o <= 1'b0;
            o_conv_run <= conv_run_nxt;
        end
    end

    // checks on the system side
    a_conv_stop: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        s_shdn_rise |=> !o_conv_run) else $error("conversions run in shutdown");
    a_temp_frozen: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        s_shdn |=> $stable(temp_r)) else $error("temperature changed in shutdown");
    a_fault_restart: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (s_conv && !s_fault) |=> fcnt_r == 3'h0) else $error("fault count not restarted");
    a_queue_bound: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        fcnt_r < need || $changed(s_fq)) else $error("fault count reached depth without trip");
    a_cmp_follow: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        !s_int |=> alert_r == dir_r) else $error("comparator alert off direction");
    a_int_latch: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (s_int && alert_r && !s_read && !s_shdn_rise) |=> alert_r) else $error("latched alert dropped");
    a_read_clear: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (s_int && s_read && !s_trip) |=> !alert_r) else $error("read did not clear alert");
    a_shdn_clear: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (s_int && s_shdn_rise && !s_trip) |=> !alert_r) else $error("shutdown did not clear alert");
    a_pin_level: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (alert_r && !s_pol && $stable(alert_r) && $stable(s_pol)) |-> o_alert_oe) else $error("alert pin not pulled");

    // checks on the link side
    a_idle_free: assert property (@(posedge i_clk_link) disable iff (i_sys_rst)
        st_r == LS_IDLE |-> !o_sda_oe) else $error("data driven while idle");
    a_temp_ro: assert property (@(posedge i_clk_link) disable iff (i_sys_rst)
        (ptr_r == PTR_TEMP) |=> $stable(cfg_r) && $stable(alarm_r) && $stable(release_r))
        else $error("write with temperature pointer changed settings");
endmodule

// File: testbench/tsa_master.sv
/* tsa_master: bit-level two-wire bus master on open-drain lines.
   assumes: both lines pulled up outside; i_clk_link runs free. */
`timescale 1ns/1ps
module tsa_master (
    input wire logic i_clk_link,
    input wire logic i_sda,
    output logic o_scl_low,
    output logic o_sda_low
);
    localparam int Q = 7; // quarter bit in link clocks, bit about 1.3 us
    // bus idle, clock stands still high
    initial begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
    end
    // wait whole quarter bits
    task automatic qw(input int n);
        repeat (n * Q) @(posedge i_clk_link);
    endtask
    // start, also repeated start from a low clock
    task automatic start();
        o_sda_low <= 1'b0;
        qw(1);
        o_scl_low <= 1'b0;
        qw(1);
        o_sda_low <= 1'b1;
        qw(1);
        o_scl_low <= 1'b1;
        qw(1);
    endtask
    // one bit cell, data set while the clock is low
    task automatic xbit(input logic b, output logic r);
        o_sda_low <= ~b;
        qw(1);
        o_scl_low <= 1'b0;
        qw(1);
        r = i_sda;
        qw(1);
        o_scl_low <= 1'b1;
        qw(1);
    endtask
    // eight bits most significant first, then the acknowledge cell
    task automatic xbyte(input logic [7:0] d, input logic b9, output logic [7:0] r, output logic a);
        logic t;
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], t);
            r[i] = t;
        end
        xbit(b9, a);
    endtask
    // stop; a slave still holding data low is clocked free first
    task automatic stop(output logic ok);
        logic t;
        o_sda_low <= 1'b0;
        qw(1);
        for (int i = 0; i < 10 && i_sda !== 1'b1; i++) xbit(1'b1, t);
        o_sda_low <= 1'b1;
        qw(1);
        o_scl_low <= 1'b0;
        qw(1);
        o_sda_low <= 1'b0;
        qw(2);
        ok = i_sda;
    endtask
endmodule

// File: testbench/tsa_core_test.sv
/* tsa_core_test: self-checking bench for the sensor core, bus traffic by tsa_master.
   assumes: pull-ups on both bus lines, conversions fed as done pulses. */
`timescale 1ns/1ps
module tsa_core_test
    import tsa_pkg::*;
();
    localparam logic [2:0] SEL = 3'h5;
    localparam int DEPTH [4] = '{1, 2, 4, 6};
    logic clk, clk_l, rst, done, m_scl_low, m_sda_low, sda_o, sda_oe, al_o, al_oe, run, a, ok;
    logic [TEMP_W-1:0] code;
    logic [15:0] q;
    logic [7:0] b;
    int errors = 0;
    int total_checks = 0;
    // wired lines with pull-ups
    wire logic scl = !m_scl_low;
    wire logic sda = !(m_sda_low || (sda_oe && !sda_o));
    tsa_core dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_clk_link(clk_l), .i_scl(scl), .i_sda(sda),
        .i_address_select_pins(SEL), .i_temp_code(code), .i_conv_done(done), .o_sda_o(sda_o),
        .o_sda_oe(sda_oe), .o_alert_o(al_o), .o_alert_oe(al_oe), .o_conv_run(run));
    tsa_master m (.i_clk_link(clk_l), .i_sda(sda), .o_scl_low(m_scl_low), .o_sda_low(m_sda_low));
    // system clock 40 ns, link clock 48 ns with its own phase
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        clk_l = 1'b0;
        #7;
        forever #24 clk_l = ~clk_l;
    end
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", s, e, g);
            errors++;
        end
    endtask
    // one bus frame: write, or read with optional pointer set first; result in q
    task automatic acc(input logic rd, setp, input logic [1:0] p, input int n, input logic nk,
                       input logic [15:0] d);
        q = 16'h0;
        m.start();
        if (setp || !rd) begin
            m.xbyte({ADDR_FIXED, SEL, 1'b0}, 1'b1, b, a);
            chk("write addr ack", 16'h0, 16'(a));
            m.xbyte({6'h0, p}, 1'b1, b, a);
            for (int i = 0; i < n && !rd; i++) begin
                m.xbyte(d[15-8*i -: 8], 1'b1, b, a);
                chk("data ack", 16'h0, 16'(a));
            end
            if (rd) m.start();
        end
        if (rd) begin
            m.xbyte({ADDR_FIXED, SEL, 1'b1}, 1'b1, b, a);
            chk("read addr ack", 16'h0, 16'(a));
            for (int i = 0; i < n; i++) begin
                m.xbyte(8'hFF, i == n - 1 ? nk : 1'b0, b, a);
                q[15-8*i -: 8] = b;
            end
        end
        m.stop(ok);
        chk("bus released", 16'h1, 16'(ok));
        repeat (20) @(posedge clk);
    endtask
    // one conversion result, then the alert pin enable
    task automatic cv(input logic [8:0] t, input logic e);
        @(posedge clk);
        code <= t;
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        repeat (2) @(posedge clk);
        chk("alert", 16'(e), 16'(al_oe));
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        rst = 1'b1;
        done = 1'b0;
        code = 9'h000;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk("alert after reset", 16'h0, 16'(al_oe));
        chk("conv run", 16'h1, 16'(run));
        acc(1, 0, PTR_TEMP, 2, 1, 0);
        chk("temp default", 16'h0, q);
        acc(1, 1, PTR_ALARM, 2, 1, 0);
        chk("alarm default", 16'h5000, q);
        acc(1, 1, PTR_RELEASE, 2, 1, 0);
        chk("release default", 16'h4B00, q);
        acc(1, 1, PTR_CFG, 1, 1, 0);
        chk("config default", 16'h0, q);
        m.start();
        m.xbyte({ADDR_FIXED, 3'h2, 1'b0}, 1'b1, b, a);
        chk("foreign addr", 16'h1, 16'(a));
        m.stop(ok);
        chk("foreign bus released", 16'h1, 16'(ok));
        acc(0, 1, PTR_RELEASE, 2, 1, 16'hFF80);
        acc(1, 0, PTR_TEMP, 2, 1, 0);
        chk("limit minus half", 16'hFF80, q);
        acc(0, 1, PTR_RELEASE, 2, 1, 16'h4B00);
        cv(9'h032, 1'b0);
        acc(0, 1, PTR_TEMP, 2, 1, 16'hAAAA);
        acc(1, 0, PTR_TEMP, 2, 1, 0);
        chk("temp read only", 16'h1900, q);
        cv(9'h0A1, 1'b1);
        cv(9'h097, 1'b1);
        cv(9'h095, 1'b0);
        // every queue code, with an in-limit result restarting the count
        for (int k = 0; k < 4; k++) begin
            acc(0, 1, PTR_CFG, 1, 1, {3'h0, 2'(k), 11'h0});
            repeat (DEPTH[k] - 1) cv(9'h0A1, 1'b0);
            cv(9'h0A0, 1'b0);
            repeat (DEPTH[k] - 1) cv(9'h0A1, 1'b0);
            cv(9'h0A1, 1'b1);
            repeat (DEPTH[k] - 1) cv(9'h095, 1'b1);
            cv(9'h095, 1'b0);
        end
        acc(0, 1, PTR_CFG, 1, 1, 16'h0400);
        chk("active high idle", 16'h1, 16'(al_oe));
        cv(9'h0A1, 1'b0);
        cv(9'h095, 1'b1);
        chk("alert never driven high", 16'h0, 16'(al_o));
        chk("data never driven high", 16'h0, 16'(sda_o));
        acc(0, 1, PTR_CFG, 1, 1, 16'h0200);
        cv(9'h0A1, 1'b1);
        cv(9'h0A0, 1'b1);
        acc(1, 0, PTR_CFG, 1, 1, 0);
        chk("read clears", 16'h0, 16'(al_oe));
        chk("config readback", 16'h0200, q);
        cv(9'h0A1, 1'b0);
        cv(9'h095, 1'b1);
        acc(1, 0, PTR_CFG, 1, 1, 0);
        cv(9'h0A1, 1'b1);
        acc(0, 1, PTR_CFG, 1, 1, 16'h0300);
        chk("shutdown clears", 16'h0, 16'(al_oe));
        chk("conv stopped", 16'h0, 16'(run));
        cv(9'h0FA, 1'b0);
        acc(1, 1, PTR_ALARM, 1, 0, 0);
        chk("short read", 16'h5000, q);
        acc(0, 1, PTR_RELEASE, 2, 1, 16'h4A80);
        acc(1, 1, PTR_TEMP, 2, 1, 0);
        chk("temp frozen", 16'h5080, q);
        acc(1, 1, PTR_RELEASE, 2, 1, 0);
        chk("release in shutdown", 16'h4A80, q);
        tally_and_finish();
    end
endmodule
